// ===== bench/bst_ctl_model.sv
// Behavioural scan controller driving the test pins
`timescale 1ns/1ps
module bst_ctl_model (
  input wire logic clk_sys_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b0;
  end
  // One TCK period of 16 system cycles; TCK stands low between steps.
  // TDO is taken four cycles after the fall, once the port has moved it.
  task automatic step(input logic tms, input logic tdi, output logic tdo_s);
    tdo_s = tdo_i;
    @(posedge clk_sys_i);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (3) @(posedge clk_sys_i);
    tck_o <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    tck_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic trst(input logic v);
    @(posedge clk_sys_i);
    trst_n_o <= v;
  endtask
endmodule

// ===== bench/bst_tap_props.sv
// Concurrent checks on the scan port, seen from the top ports
`timescale 1ns/1ps
module bst_tap_props
  import bst_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic test_mode_o,
  input wire logic [7:0] bsr_drive_o,
  input wire logic [3:0] tap_state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire shf = tap_state_o == BST_SHF_DR || tap_state_o == BST_SHF_IR;
  chk_oe_shift: assert property ($rose(tdo_oe_o) |-> shf) else $error("oe outside shift");
  chk_oe_idle: assert property ((tap_state_o == BST_RTI) [*8] |-> !tdo_oe_o) else $error("oe in idle");
  chk_trst_tlr: assert property (!trst_n_i [*4] |-> tap_state_o == BST_TLR) else $error("no trst reset");
  chk_mode_tlr: assert property (tap_state_o == BST_TLR |-> !test_mode_o) else $error("mode in reset");
  chk_rise_lag: assert property ($rose(tck_i) |=> $stable(tap_state_o) [*2]) else $error("state early");
  chk_tdo_fall: assert property ($rose(tck_i) |=> $stable(tdo_o) [*8]) else $error("tdo on rise");
  // Sync pipeline is two deep, so six quiet cycles leave nothing in flight
  chk_state_hold: assert property (($stable(tck_i) && trst_n_i) [*6] |=> $stable(tap_state_o))
    else $error("state moved");
  chk_bsr_upd: assert property ($changed(bsr_drive_o) |-> tap_state_o inside {BST_UPD_DR, BST_TLR}
    || $past(tap_state_o) == BST_UPD_DR) else $error("bsr moved");
endmodule
bind bst_tap bst_tap_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .test_mode_o(test_mode_o), .bsr_drive_o(bsr_drive_o),
  .tap_state_o(tap_state_o));

// ===== bench/testbench.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`include "bst_regs.svh"
module testbench;
  import bst_pkg::*;
  logic clk_sys_i, rst_i, tck, tms, tdi, trst_n, tdo, oe, mode, d;
  logic [7:0] pins, bsr;
  logic [3:0] st;
  logic [31:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  bst_tap u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .core_pins_i(pins), .tdo_o(tdo), .tdo_oe_o(oe), .test_mode_o(mode), .bsr_drive_o(bsr), .tap_state_o(st));
  bst_ctl_model u_ctl (.clk_sys_i(clk_sys_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // TMS path to a shift state, n bits LSB first, then Update and Idle
  task automatic scan(input logic [3:0] path, input int np, input int n, input logic [31:0] din);
    rd = '0;
    for (int i = 0; i < np; i++) u_ctl.step(path[i], 1'b1, d);
    for (int i = 0; i < n; i++) begin
      chk("oe", 1, oe);
      u_ctl.step(i == n - 1, din[i], d);
      rd[i] = d;
    end
    u_ctl.step(1'b1, 1'b1, d);
    u_ctl.step(1'b0, 1'b1, d);
    chk("oe", 0, oe);
  endtask
  task automatic t_ident;
    u_ctl.trst(1'b1);
    repeat (4) @(posedge clk_sys_i);
    chk("state", BST_TLR, st);
    scan(4'b0010, 4, 32, 0);
    chk("id", {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MFR, 1'b1}, rd);
  endtask
  task automatic t_abort;
    for (int i = 0; i < 3; i++) u_ctl.step(i == 0, 1'b1, d);
    chk("oe", 1, oe);
    u_ctl.trst(1'b0);
    repeat (5) @(posedge clk_sys_i);
    chk("state", BST_TLR, st);
    chk("oe", 0, oe);
    u_ctl.trst(1'b1);
    u_ctl.step(1'b0, 1'b1, d);
  endtask
  task automatic t_bypass;
    for (int k = 0; k < 2; k++) begin
      scan(4'b0011, 4, 4, k ? 32'h5 : `BST_IR_BYPASS);
      chk("ir", 32'h1, rd);
      scan(4'b0001, 3, 8, 32'hC5);
      chk("bypass", 32'h8A, rd);
    end
  endtask
  task automatic t_sample;
    scan(4'b0011, 4, 4, `BST_IR_SAMPLE);
    scan(4'b0001, 3, 8, 32'h3C);
    chk("sample", 32'hA5, rd);
    chk("bsr", 32'h3C, bsr);
  endtask
  task automatic t_extest;
    scan(4'b0011, 4, 4, `BST_IR_EXTEST);
    chk("mode", 1, mode);
    for (int i = 0; i < 5; i++) u_ctl.step(1'b1, 1'b1, d);
    chk("state", BST_TLR, st);
    chk("mode", 0, mode);
  endtask
  initial begin
    rst_i = 1'b1;
    pins = 8'hA5;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    t_ident;
    t_abort;
    t_bypass;
    t_sample;
    t_extest;
    close_out;
  end
  initial begin
    #400000;
    num_errors++;
    close_out;
  end
endmodule

// ===== hdl/bst_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module bst_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // Reset loads the caller's rst_val_i into both stages; a pin at another level shows an edge two cycles after reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= rst_val_i;
      sync_q <= rst_val_i;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule

// ===== hdl/bst_tap.sv
// Boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/1ps
`include "bst_regs.svh"
//
// Behaviour
// - TMS sampled on rising TCK steps the port controller.
// - TDI captured on rising TCK edges.
// - TDO updated on falling TCK from the selected register.
// - TDO driver off whenever nothing is shifting.
// - Undriven TMS, TDI and TRST read as one; no pull-ups here, only reset loads the synchroniser with ones.
// - TRST low resets controller and instruction register at once.
// - Scan logic stepped by TCK only, independent of functional clocks; here TCK edges are sampled on clk_sys_i.
// - TDI routed to instruction or data register by controller state.
// - Four-bit instruction register shifts only in Shift-IR.
// - Instruction selects active data register and serial path.
// - Public instructions EXTEST, SAMPLE/PRELOAD, IDCODE, BYPASS supported.
// - Exactly three data registers: boundary, bypass, identification.
// - Boundary register forms one continuous chain around core pins.
// - Bypass inserts one shift stage between TDI and TDO.
// - Fixed 32-bit identification, version in bits 31:28, LSB first.
module bst_tap
  import bst_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = `BST_ID_VERSION,
  parameter logic [15:0] ID_PART = `BST_ID_PART, // Arbitrary value
  parameter logic [10:0] ID_MFR = `BST_ID_MFR // Arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  input wire logic [`BST_BSR_LEN-1:0] core_pins_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic test_mode_o,
  output logic [`BST_BSR_LEN-1:0] bsr_drive_o,
  output logic [3:0] tap_state_o
);
  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  bst_pins_t pins_raw;
  bst_pins_t pins_s;
  assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};

  bst_sync #(.W(4)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .rst_val_i(4'hF),
    .sync_o(pins_s)
  );

  // TCK edges found by the system clock; the pins never clock a flop,
  // so scan activity cannot disturb functional timing.
  logic tck_prev_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tck_prev_q <= 1'b1;
    end else begin
      tck_prev_q <= pins_s.tck;
    end
  end
  wire tck_rise = pins_s.tck & ~tck_prev_q;
  wire tck_fall = ~pins_s.tck & tck_prev_q;
  wire trst_act = ~pins_s.trst_n;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  bst_state_t state_q;
  bst_state_t state_d;
  wire tms = pins_s.tms;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BST_TLR: state_d = tms ? BST_TLR : BST_RTI;
      BST_RTI: state_d = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: state_d = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_d = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_SHF_DR: state_d = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_EX1_DR: state_d = tms ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: state_d = tms ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: state_d = tms ? BST_UPD_DR : BST_SHF_DR;
      BST_UPD_DR: state_d = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: state_d = tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: state_d = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_SHF_IR: state_d = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_EX1_IR: state_d = tms ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: state_d = tms ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: state_d = tms ? BST_UPD_IR : BST_SHF_IR;
      BST_UPD_IR: state_d = tms ? BST_SEL_DR : BST_RTI;
    endcase
  end

  // TRST acts at once, without waiting for a TCK edge.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || trst_act) begin
      state_q <= BST_TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [`BST_IR_W-1:0] ir_sh_q;
  logic [`BST_IR_W-1:0] ir_q;
  wire in_tlr = (state_q == BST_TLR);
  wire ir_shift = tck_rise && (state_q == BST_SHF_IR);
  wire ir_cap = tck_rise && (state_q == BST_CAP_IR);
  wire ir_upd = tck_rise && (state_q == BST_UPD_IR);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || trst_act || in_tlr) begin
      ir_sh_q <= `BST_IR_CAPTURE;
      ir_q <= `BST_IR_RESET;
    end else begin
      if (ir_cap) begin
        ir_sh_q <= `BST_IR_CAPTURE;
      end else if (ir_shift) begin
        ir_sh_q <= {pins_s.tdi, ir_sh_q[`BST_IR_W-1:1]};
      end
      if (ir_upd) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire sel_bsr = (ir_q == `BST_IR_EXTEST) || (ir_q == `BST_IR_SAMPLE);
  wire sel_id = (ir_q == `BST_IR_IDCODE);
  // Unknown codes fall to bypass, as the standard asks
  wire sel_byp = ~sel_bsr & ~sel_id;

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  wire [31:0] id_code = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  logic [31:0] id_q;
  logic byp_q;
  logic [`BST_BSR_LEN-1:0] bsr_q;
  logic [`BST_BSR_LEN-1:0] bsr_upd_q;
  wire dr_cap = tck_rise && (state_q == BST_CAP_DR);
  wire dr_shift = tck_rise && (state_q == BST_SHF_DR);
  wire dr_upd = tck_rise && (state_q == BST_UPD_DR);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || trst_act) begin
      id_q <= 32'h0000_0000;
      byp_q <= 1'b0;
      bsr_q <= '0;
    end else if (dr_cap) begin
      id_q <= id_code;
      byp_q <= 1'b0;
      bsr_q <= core_pins_i;
    end else if (dr_shift) begin
      if (sel_id) begin
        id_q <= {pins_s.tdi, id_q[31:1]};
      end
      if (sel_byp) begin
        byp_q <= pins_s.tdi;
      end
      if (sel_bsr) begin
        bsr_q <= {pins_s.tdi, bsr_q[`BST_BSR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || trst_act) begin
      bsr_upd_q <= '0;
    end else if (dr_upd && sel_bsr) begin
      bsr_upd_q <= bsr_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  wire dr_bit = sel_id ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q);
  wire shifting = (state_q == BST_SHF_DR) || (state_q == BST_SHF_IR);
  wire out_bit = (state_q == BST_SHF_IR) ? ir_sh_q[0] : dr_bit;
  logic tdo_q;
  logic tdo_oe_q;

  // Change on falling TCK so the tester samples a settled bit on rising
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || trst_act) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= out_bit;
      tdo_oe_q <= shifting;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign test_mode_o = (ir_q == `BST_IR_EXTEST) && !in_tlr;
  assign bsr_drive_o = bsr_upd_q;
  assign tap_state_o = state_q;
endmodule

// ===== shared/bst_pkg.sv
// Types of the boundary-scan test port
package bst_pkg;
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SHF_DR, BST_EX1_DR, BST_PAU_DR, BST_EX2_DR, BST_UPD_DR,
    BST_SEL_IR, BST_CAP_IR, BST_SHF_IR, BST_EX1_IR, BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_t;
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_out_t;
endpackage

// ===== shared/bst_regs.svh
// Constants of the boundary-scan test port
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_IR_W 4
`define BST_IR_EXTEST 4'h0
`define BST_IR_SAMPLE 4'h1
`define BST_IR_IDCODE 4'h2
`define BST_IR_BYPASS 4'hF
`define BST_IR_CAPTURE 4'h1
`define BST_IR_RESET 4'h2
// Arbitrary version value
`define BST_ID_VERSION 4'h3
`define BST_ID_PART 16'h1234
`define BST_ID_MFR 11'h155
`define BST_BSR_LEN 8
`define BST_TRST_SETTLE 2'h3
`endif
